// [core/uncore_event_counter_unit.v]
/*
 * Uncore event counter unit: cache-slice boxes and one arbiter_unit box,
 * two counters each, a 48-bit clock-tick counter, global freeze and
 * overflow interrupt routing with an optional wake request, over AXI4-Lite.
 * Assumes one clock, synchronous event inputs and one event per box per cycle.
 */
//
// Behaviour
// - occupancy events count only on counter 0 of a slice box, on both arbiter_unit counters
// - other slice events count on either counter
// - up to four slice boxes, each own registers
// - counts core-initiated cache transactions
// - no per-thread qualification, all threads merged
// - event select code, mask, edge, invert, threshold
// - freeze clears global enable on overflow
// - wake request goes out before core_irq_ff; an unmasked irq_ff rises with it
// - fixed counter ticks every clock while enabled
`include "uncore_event_counter_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module uncore_event_counter_unit #(
    parameter NUM_SLICES = 4,   // product dependent, at most 4
    parameter NUM_CORES  = 4
) (
    // clock and reset
    input  wire                           clk,
    input  wire                           srst,
    // events, one lane per box; the last lane is the arbiter_unit
    input  wire [(NUM_SLICES+1)*8-1:0]    evt_code,
    input  wire [(NUM_SLICES+1)*8-1:0]    evt_unit,
    input  wire [(NUM_SLICES+1)*5-1:0]    evt_amount,
    input  wire [NUM_SLICES:0]            evt_occupancy,
    // cores
    output reg  [NUM_CORES-1:0]           core_wake_ff,
    output reg  [NUM_CORES-1:0]           core_irq_ff,
    output reg                            irq_ff,
    // axi4-lite write address
    input  wire [11:0]                    s_axi_awaddr,
    input  wire                           s_axi_awvalid,
    output reg                            s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]                    s_axi_wdata,
    input  wire [3:0]                     s_axi_wstrb,
    input  wire                           s_axi_wvalid,
    output reg                            s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]                     s_axi_bresp,
    output reg                            s_axi_bvalid,
    input  wire                           s_axi_bready,
    // axi4-lite read address
    input  wire [11:0]                    s_axi_araddr,
    input  wire                           s_axi_arvalid,
    output reg                            s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]                    s_axi_rdata,
    output reg  [1:0]                     s_axi_rresp,
    output reg                            s_axi_rvalid,
    input  wire                           s_axi_rready
);

    localparam NBOX = NUM_SLICES + 1;      // slices plus arbiter_unit
    localparam NCTR = 2 * NBOX;            // two counters a box
    localparam NST  = NCTR + 1;            // status bits, fixed counter last
    localparam CW   = `BOX_CNT_W;
    localparam FW   = `FIXED_CNT_W;

    // register state
    reg  [31:0]         gctrl_ff;          // global control
    reg  [31:0]         sel_ff [0:NCTR-1]; // event selects
    reg  [NST-1:0]      status_ff;         // sticky overflow bits
    reg  [NST-1:0]      mask_ff;           // interrupt mask
    reg  [FW-1:0]       fixed_ff;          // uncore clock ticks
    // bus state
    reg  [11:0]         awaddr_ff;         // held write address
    reg                 aw_held_ff;        // address taken, not yet used
    reg  [31:0]         wdata_ff;          // held write data
    reg  [3:0]          wstrb_ff;          // held byte strobes
    reg                 w_held_ff;         // data taken, not yet used
    // interrupt sequencing
    reg                 wake_pend_ff;      // interrupt waits behind wake
    reg  [NUM_CORES-1:0] pend_cores_ff;    // cores owed that interrupt

    wire [CW-1:0]       cnt   [0:NCTR-1];  // counter values
    wire [NCTR-1:0]     ovf;               // raw overflow pulses
    wire [NST-1:0]      fwd;               // forwarded overflows
    wire                fixed_wrap;        // fixed counter overflow
    wire                gen;               // global enable
    wire                do_write;          // both halves of a write held
    wire                wbox_hit;          // write lands in a box window
    wire [11:0]         woff;              // write offset past box base
    wire [6:0]          wbox;              // box addressed, no aliasing
    wire [31:0]         mask_merged;       // mask after byte-lane merge
    wire [31:0]         fhi_merged;        // fixed hi after byte merge
    wire [2:0]          wsub;              // word inside box window
    wire                ar_take;           // read address handshake
    reg  [31:0]         rd_data;           // read mux result
    reg                 rd_ok;             // read address mapped
    reg                 wr_ok;             // write address mapped
    reg  [NST-1:0]      rd_clear;          // status bits a read clears
    integer             k;                 // read mux loop
    integer             j;                 // select write loop

    assign gen      = gctrl_ff[`GC_ENABLE_BIT];
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wbox_hit = (awaddr_ff >= `OFS_BOX_BASE);
    assign woff     = awaddr_ff - `OFS_BOX_BASE;
    // all upper offset bits kept so far addresses never alias box 0
    assign wbox     = woff[11:`BOX_STRIDE_SHIFT];
    assign mask_merged = merge({{(32-NST){1'b0}}, mask_ff}, wdata_ff,
                               wstrb_ff);
    assign fhi_merged  = merge({{(64-FW){1'b0}}, fixed_ff[FW-1:32]},
                               wdata_ff, wstrb_ff);
    assign wsub     = awaddr_ff[4:2];
    assign ar_take  = s_axi_arvalid && s_axi_arready;

    // byte-lane merge of a held write into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer      b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // per-counter slices; counter 1 of a slice box refuses occupancy
    genvar i;
    generate
        for (i = 0; i < NCTR; i = i + 1) begin : g_ctr
            wire        wlo;
            wire        whi;
            wire [31:0] wmerged;
            wire [63:0] cnt_wide;
            assign cnt_wide = {{(64-CW){1'b0}}, cnt[i]};
            assign wlo = do_write && wbox_hit && (wbox == (i / 2)) &&
                         (wsub == (`BOXW_CNT0_LO + 2 * (i % 2)));
            assign whi = do_write && wbox_hit && (wbox == (i / 2)) &&
                         (wsub == (`BOXW_CNT0_HI + 2 * (i % 2)));
            assign wmerged = merge(whi ? cnt_wide[63:32] : cnt_wide[31:0],
                                   wdata_ff, wstrb_ff);
            // forwarded only with overflow_forward_enable set
            assign fwd[i] = ovf[i] && sel_ff[i][`ES_OVF_FWD_BIT];
            event_counter_slice #(
                .CNT_W (CW)
            ) u_slice (
                .clk             (clk),
                .srst            (srst),
                .global_en       (gen),
                .allow_occupancy ((i % 2 == 0) || (i / 2 == NUM_SLICES)),
                .sel             (sel_ff[i]),
                .evt_code        (evt_code[(i/2)*8 +: 8]),
                .evt_unit        (evt_unit[(i/2)*8 +: 8]),
                .evt_amount      (evt_amount[(i/2)*5 +: 5]),
                .evt_occupancy   (evt_occupancy[i/2]),
                .wr_lo           (wlo),
                .wr_hi           (whi),
                .wdata           (wmerged),
                .count_ff        (cnt[i]),
                .ovf_ff          (ovf[i])
            );
        end
    endgenerate

    assign fixed_wrap = gen && (fixed_ff == {FW{1'b1}});
    assign fwd[NCTR]  = fixed_wrap;

    // write decode: mapped words only, rest answered with slverr
    always @* begin
        wr_ok = 1'b0;
        case (awaddr_ff)
            `OFS_GLOBAL_CTRL, `OFS_OVF_STATUS, `OFS_OVF_MASK,
            `OFS_FIXED_LO, `OFS_FIXED_HI: wr_ok = 1'b1;
            default: wr_ok = wbox_hit && (wbox < NBOX) && (wsub <= `BOXW_CNT1_HI);
        endcase
    end

    // read mux; status read also reports which bits it clears
    always @* begin
        rd_data  = 32'h00000000;
        rd_ok    = 1'b1;
        rd_clear = {NST{1'b0}};
        case (s_axi_araddr)
            `OFS_GLOBAL_CTRL: rd_data = gctrl_ff;
            `OFS_OVF_STATUS: begin
                rd_data  = {{(32-NST){1'b0}}, status_ff};
                rd_clear = status_ff;
            end
            `OFS_OVF_MASK: rd_data = {{(32-NST){1'b0}}, mask_ff};
            `OFS_FIXED_LO: rd_data = fixed_ff[31:0];
            `OFS_FIXED_HI: rd_data = {{(64-FW){1'b0}}, fixed_ff[FW-1:32]};
            default: begin
                rd_ok = 1'b0;
                for (k = 0; k < NCTR; k = k + 1) begin
                    if (s_axi_araddr == `OFS_BOX_BASE + (k / 2) * 32 + (k % 2) * 4) begin
                        rd_data = sel_ff[k];
                        rd_ok   = 1'b1;
                    end
                    if (s_axi_araddr == `OFS_BOX_BASE + (k / 2) * 32 + 8 + (k % 2) * 8) begin
                        rd_data = cnt[k][31:0];
                        rd_ok   = 1'b1;
                    end
                    if (s_axi_araddr == `OFS_BOX_BASE + (k / 2) * 32 + 12 + (k % 2) * 8) begin
                        rd_data = {{(64-CW){1'b0}}, cnt[k][CW-1:32]};
                        rd_ok   = 1'b1;
                    end
                end
            end
        endcase
    end

    // write channel: address and data taken in either order
    always @(posedge clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            awaddr_ff     <= 12'h000;
            wdata_ff      <= 32'h00000000;
            wstrb_ff      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff     <= s_axi_awaddr;
                aw_held_ff    <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                w_held_ff    <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            // ready comes back only after the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: one cycle to data, ready held low until rready
    always @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_rdata   <= rd_data;
                s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // control registers, freeze and fixed counter
    always @(posedge clk) begin
        if (srst) begin
            gctrl_ff <= `GC_RESET;
            mask_ff  <= {NST{1'b0}};
            fixed_ff <= {FW{1'b0}};
            for (j = 0; j < NCTR; j = j + 1) begin
                sel_ff[j] <= `ES_RESET;
            end
        end else begin
            if (gen) begin
                fixed_ff <= fixed_ff + {{(FW-1){1'b0}}, 1'b1};
            end
            if (do_write && wr_ok) begin
                case (awaddr_ff)
                    `OFS_GLOBAL_CTRL: gctrl_ff <= merge(gctrl_ff, wdata_ff, wstrb_ff);
                    `OFS_OVF_MASK: mask_ff <= mask_merged[NST-1:0];
                    `OFS_FIXED_LO: fixed_ff[31:0] <= merge(fixed_ff[31:0], wdata_ff,
                                                           wstrb_ff);
                    `OFS_FIXED_HI: fixed_ff[FW-1:32] <= fhi_merged[FW-33:0];
                    default: begin
                        for (j = 0; j < NCTR; j = j + 1) begin
                            if (wbox == (j / 2) && wsub == (j % 2)) begin
                                sel_ff[j] <= merge(sel_ff[j], wdata_ff, wstrb_ff) &
                                             `ES_WRITE_MASK;
                            end
                        end
                    end
                endcase
            end
            // hardware clear of the global enable beats a software set
            if (gctrl_ff[`GC_FREEZE_BIT] && gen && (|fwd)) begin
                gctrl_ff[`GC_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // sticky status, set wins over the clear of a status read
    always @(posedge clk) begin
        if (srst) begin
            status_ff <= {NST{1'b0}};
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= (status_ff & ~(ar_take ? rd_clear : {NST{1'b0}})) | fwd;
            irq_ff    <= |(((status_ff & ~(ar_take ? rd_clear : {NST{1'b0}})) | fwd)
                           & mask_ff);
        end
    end

    // core routing: wake first when asked, interrupt one cycle later
    always @(posedge clk) begin
        if (srst) begin
            core_wake_ff  <= {NUM_CORES{1'b0}};
            core_irq_ff   <= {NUM_CORES{1'b0}};
            wake_pend_ff  <= 1'b0;
            pend_cores_ff <= {NUM_CORES{1'b0}};
        end else begin
            core_wake_ff <= {NUM_CORES{1'b0}};
            core_irq_ff  <= {NUM_CORES{1'b0}};
            wake_pend_ff <= 1'b0;
            if (wake_pend_ff) begin
                core_irq_ff <= pend_cores_ff;
            end
            if (|fwd) begin
                if (gctrl_ff[`GC_WAKE_BIT]) begin
                    core_wake_ff  <= gctrl_ff[NUM_CORES-1:0];
                    pend_cores_ff <= gctrl_ff[NUM_CORES-1:0];
                    wake_pend_ff  <= 1'b1;
                end else begin
                    core_irq_ff <= gctrl_ff[NUM_CORES-1:0];
                end
            end
        end
    end

endmodule // uncore_event_counter_unit

`default_nettype wire

// [core/uncore_event_counter_defs.vh]
/*
 * Offsets, field positions, reset values and timing counts shared by the
 * uncore event counter unit and its counter slice.
 * Assumes a 32-bit register word and byte addresses on the bus.
 */
`ifndef UNCORE_EVENT_COUNTER_DEFS_VH
`define UNCORE_EVENT_COUNTER_DEFS_VH

// register byte offsets (low 12 address bits decoded)
`define OFS_GLOBAL_CTRL     12'h000
`define OFS_OVF_STATUS      12'h004
`define OFS_OVF_MASK        12'h008
`define OFS_FIXED_LO        12'h00C
`define OFS_FIXED_HI        12'h010
`define OFS_BOX_BASE        12'h040
`define BOX_STRIDE_SHIFT    5
// word index inside one box window
`define BOXW_SEL0           3'h0
`define BOXW_SEL1           3'h1
`define BOXW_CNT0_LO        3'h2
`define BOXW_CNT0_HI        3'h3
`define BOXW_CNT1_LO        3'h4
`define BOXW_CNT1_HI        3'h5

// global control fields
`define GC_CORE_SEL_HI      3
`define GC_CORE_SEL_LO      0
`define GC_ENABLE_BIT       29
`define GC_WAKE_BIT         30
`define GC_FREEZE_BIT       31
`define GC_RESET            32'h00000000

// event-select fields
`define ES_CODE_HI          7
`define ES_CODE_LO          0
`define ES_UNIT_MASK_HI         15
`define ES_UNIT_MASK_LO         8
`define ES_EDGE_BIT         18
`define ES_OVF_FWD_BIT      20
`define ES_LOCAL_EN_BIT     22
`define ES_INVERT_BIT       23
`define ES_THRESH_HI        28
`define ES_THRESH_LO        24
`define ES_RESET            32'h00000000
`define ES_WRITE_MASK       32'h1FD4FFFF

// widths
`define BOX_CNT_W           44
`define FIXED_CNT_W         48

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

// wake request leads the core interrupt by this many uncore clocks
`define WAKE_LEAD_CYCLES    1

`endif

// [core/event_counter_slice.v]
/*
 * One general purpose 44-bit event counter with its event-select filter.
 * Assumes the event inputs are already merged over all threads and that
 * software writes arrive as whole merged words from the register file.
 */
`include "uncore_event_counter_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module event_counter_slice #(
    parameter CNT_W = `BOX_CNT_W
) (
    // clock and reset
    input  wire             clk,
    input  wire             srst,
    // control
    input  wire             global_en,
    input  wire             allow_occupancy,
    input  wire [31:0]      sel,
    // event presented by the box this cycle
    input  wire [7:0]       evt_code,
    input  wire [7:0]       evt_unit,
    input  wire [4:0]       evt_amount,
    input  wire             evt_occupancy,
    // software load
    input  wire             wr_lo,
    input  wire             wr_hi,
    input  wire [31:0]      wdata,
    // state
    output reg  [CNT_W-1:0] count_ff,
    output reg              ovf_ff
);

    wire       [4:0]       thresh;      // count_threshold field
    wire                   hit;         // event selected by code and unit_mask
    wire                   over;        // amount meets threshold
    wire                   cond;        // filtered condition, after invert
    reg                    cond_d_ff;   // previous condition, for edge detect
    reg        [4:0]       inc;         // amount to add this cycle
    wire       [CNT_W:0]   sum;         // one extra bit catches the wrap

    assign thresh = sel[`ES_THRESH_HI:`ES_THRESH_LO];
    // occupancy only where the box allows it; counter 1 of a slice box ignores them
    assign hit = (sel[`ES_CODE_HI:`ES_CODE_LO] == evt_code) &&
                 ((sel[`ES_UNIT_MASK_HI:`ES_UNIT_MASK_LO] & evt_unit) != 8'h00) &&
                 (allow_occupancy || !evt_occupancy);
    assign over = (evt_amount >= thresh);
    assign cond = hit && (over ^ sel[`ES_INVERT_BIT]);

    // increment choice: raw amount, threshold compare, or edge
    always @* begin
        inc = 5'h00;
        if (thresh == 5'h00 && !sel[`ES_EDGE_BIT] && !sel[`ES_INVERT_BIT]) begin
            inc = hit ? evt_amount : 5'h00;
        end else if (sel[`ES_EDGE_BIT]) begin
            inc = (cond && !cond_d_ff) ? 5'h01 : 5'h00;
        end else begin
            inc = cond ? 5'h01 : 5'h00;
        end
    end

    assign sum = {1'b0, count_ff} + {{(CNT_W-4){1'b0}}, inc};

    // counter, software load wins over counting in the same cycle
    always @(posedge clk) begin
        if (srst) begin
            count_ff  <= {CNT_W{1'b0}};
            ovf_ff    <= 1'b0;
            cond_d_ff <= 1'b0;
        end else begin
            cond_d_ff <= cond;
            ovf_ff    <= 1'b0;
            if (wr_lo) begin
                count_ff[31:0] <= wdata;
            end else if (wr_hi) begin
                count_ff[CNT_W-1:32] <= wdata[CNT_W-33:0];
            end else if (global_en && sel[`ES_LOCAL_EN_BIT]) begin
                count_ff <= sum[CNT_W-1:0];
                ovf_ff   <= sum[CNT_W];
            end
        end
    end

endmodule // event_counter_slice

`default_nettype wire

// [verification/core_model.sv]
/* partner: cores taking overflow interrupts.
   assumes a core is halted unless woken the cycle before. */
`timescale 1ns/1ps
`default_nettype none
module core_model #(
    parameter NC = 4
) (
    input  wire logic [NC-1:0] wake,
    input  wire logic [NC-1:0] irq,
    input  wire logic          clk,
    input  wire logic          srst,
    output var  logic [NC-1:0] served_ff,
    output var  logic [NC-1:0] missed_ff
);
    logic [NC-1:0] awake_ff; // woken last cycle
    // a halted core drops an interrupt that came without a wake
    always @(posedge clk) begin
        if (srst) begin
            awake_ff  <= '0;
            served_ff <= '0;
            missed_ff <= '0;
        end else begin
            awake_ff  <= wake;
            served_ff <= served_ff | (irq & awake_ff);
            missed_ff <= missed_ff | (irq & ~awake_ff);
        end
    end
endmodule // core_model
`default_nettype wire

// [verification/uncore_event_counter_checker.sv]
/* handshake and interrupt order checks.
   assumes binding to the unit top ports. */
`timescale 1ns/1ps
`default_nettype none
module uncore_event_counter_checker #(
    parameter NUM_CORES = 4
) (
    input wire logic                 clk,
    input wire logic                 srst,
    input wire logic [NUM_CORES-1:0] core_wake_ff,
    input wire logic [NUM_CORES-1:0] core_irq_ff,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // both write halves taken together
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wake_pulse;
        core_wake_ff != '0;
    endsequence
    AST_WR_ANSWER: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read data late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    AST_W_BLOCK: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("second write");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read");
    AST_WAKE_LEAD: assert property (wake_pulse |=> core_irq_ff ==
        $past(core_wake_ff)) else $error("interrupt not after wake");
    AST_IRQ_PULSE: assert property (core_irq_ff != '0
        |=> core_irq_ff == '0) else $error("interrupt not a pulse");
endmodule // uncore_event_counter_checker
`default_nettype wire

// [verification/tb_uncore_event_counter_unit.sv]
/* testbench for the uncore event counter unit.
   assumes the defs header on the include path. */
`include "uncore_event_counter_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_uncore_event_counter_unit;
    logic clk = 0, srst = 1;
    logic [39:0] evt_code = 0, evt_unit = 0;
    logic [24:0] evt_amount = 0;
    logic [4:0]  evt_occupancy = 0;
    wire  [3:0]  core_wake_ff, core_irq_ff, served_ff, missed_ff;
    wire         irq_ff;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire  s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire  s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int fails = 0, compares = 0, cyc = 0;
    always #12.5 clk = ~clk; // 40 MHz
    always @(posedge clk) cyc <= cyc + 1;
    // every bench signal carries its port's name
    uncore_event_counter_unit i_uncore_event_counter_unit (.*);
    core_model i_core_model (.wake(core_wake_ff), .irq(core_irq_ff),
        .clk(clk), .srst(srst), .served_ff(served_ff),
        .missed_ff(missed_ff));
    task chk(input [63:0] got, input [63:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // master write, each half released when taken, b stalled one cycle
    task wr(input [11:0] a, input [31:0] d, input [1:0] er);
        bit ta, tw;
        ta = 0;
        tw = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (!(ta && tw)) begin
            @(posedge clk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1;
        @(posedge clk);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
    endtask
    // master read; t gives the cycle the address was taken
    task rd(input [11:0] a, output [31:0] d, output [1:0] r, output int t);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        t = cyc;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1;
        @(posedge clk);
        s_axi_rready <= 0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task rdchk(input [11:0] a, input [31:0] e);
        logic [31:0] d; logic [1:0] r; int t;
        rd(a, d, r, t);
        chk({r, d}, {`RESP_OKAY, e});
    endtask
    // one event on lane b for n cycles
    task ev(input int b, input occ, input [4:0] amt, input int n);
        @(posedge clk);
        evt_code[b*8 +: 8] <= 8'h12;
        evt_unit[b*8 +: 8] <= 8'h01;
        evt_amount[b*5 +: 5] <= amt;
        evt_occupancy[b] <= occ;
        repeat (n) @(posedge clk);
        evt_code <= '0; evt_unit <= '0; evt_amount <= '0; evt_occupancy <= '0;
    endtask
    task t_reset();
        logic [31:0] d; logic [1:0] r; int t;
        rdchk(`OFS_GLOBAL_CTRL, 32'h00000000);
        rd(12'hFFC, d, r, t);
        chk({r, d}, {`RESP_SLVERR, 32'h00000000});
        wr(12'hFFC, 32'h00000001, `RESP_SLVERR);
    endtask
    task t_fixed();
        logic [31:0] d1, d2; logic [1:0] r; int t1, t2;
        wr(`OFS_GLOBAL_CTRL, 32'h20000000, `RESP_OKAY);
        rd(`OFS_FIXED_LO, d1, r, t1);
        rd(`OFS_FIXED_LO, d2, r, t2);
        chk(d2 - d1, t2 - t1);
    endtask
    // occupancy counts only on counter 0 of slices, both on arbiter
    task t_box(input int b);
        logic [11:0] base;
        base = `OFS_BOX_BASE + 12'h020 * b;
        wr(base, 32'h00400112, `RESP_OKAY);
        wr(base + 12'h004, 32'h00400112, `RESP_OKAY);
        ev(b, 0, 5'h03, 5);
        ev(b, 1, 5'h02, 4);
        rdchk(base + 12'h008, 32'h00000017);
        rdchk(base + 12'h010, b == 4 ? 32'h17 : 32'h0F);
    endtask
    task t_ovf();
        int k;
        wr(`OFS_OVF_MASK, 32'h00000000, `RESP_OKAY);
        wr(12'h048, 32'hFFFFFFFF, `RESP_OKAY);
        wr(12'h04C, 32'h00000FFF, `RESP_OKAY);
        wr(12'h040, 32'h00500112, `RESP_OKAY);
        wr(`OFS_GLOBAL_CTRL, 32'hE0000005, `RESP_OKAY);
        ev(0, 0, 5'h01, 1);
        k = 0;
        do begin @(posedge clk); k++; end while (core_wake_ff == 0 && k < 40);
        chk(core_wake_ff, 4'h5);
        @(posedge clk);
        chk(core_irq_ff, 4'h5);
        repeat (2) @(posedge clk);
        chk({missed_ff, served_ff}, 8'h05);
        rdchk(`OFS_GLOBAL_CTRL, 32'hC0000005);
        chk(irq_ff, 1'b0);
        wr(`OFS_OVF_MASK, 32'h00000001, `RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(irq_ff, 1'b1);
        rdchk(`OFS_OVF_STATUS, 32'h00000001);
        rdchk(`OFS_OVF_STATUS, 32'h00000000);
        chk(irq_ff, 1'b0);
    endtask
    task complete_run();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 0;
        t_reset();
        t_fixed();
        for (int b = 0; b < 5; b++) t_box(b);
        t_ovf();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule // tb_uncore_event_counter_unit
bind uncore_event_counter_unit uncore_event_counter_checker #(
    .NUM_CORES(NUM_CORES)) i_uncore_event_counter_checker (.*);
`default_nettype wire
